// ==== design/lcdc_alternator.sv ====
/*
 * lcdc_alternator: generates the lcd alternation signal.
 * assumes: line and frame ticks are one-cycle pulses on clock_i.
 */
`timescale 1ns/10ps
module lcdc_alternator
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // timing ticks
    input wire logic line_tick_i,
    input wire logic frame_tick_i,
    // configuration
    input wire logic enable_i,
    input wire logic [5:0] count_i,
    // alternation output
    output logic alt_o
);
    // whole state of this module
    typedef struct packed {
        logic [5:0] lines;
        logic alt;
    } lcdc_alt_state_t;

    lcdc_alt_state_t state_q;
    lcdc_alt_state_t state_d;

    // next state: per n lines or per frame
    always_comb
    begin
        state_d = state_q;
        if (enable_i)
        begin
            // toggle after count+1 lines
            if (line_tick_i)
            begin
                if (state_q.lines >= count_i) // [R10] [R11]
                begin
                    state_d.lines = 6'h00;
                    state_d.alt = ~state_q.alt;
                end
                else
                begin
                    state_d.lines = state_q.lines + 6'h01;
                end
            end
        end
        else
        begin
            // count ignored, once per frame
            state_d.lines = 6'h00;
            if (frame_tick_i)
            begin
                state_d.alt = ~state_q.alt; // [R11]
            end
        end
    end

    // state register
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign alt_o = state_q.alt;

    a_alt_frame: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R11]
        (!enable_i && !frame_tick_i) |=> $stable(alt_o))
        else $error("alternation moved without a frame tick");
endmodule : lcdc_alternator

// ==== design/lcdc_decoder.sv ====
/*
 * lcdc_decoder: command decoder and display-ram access for a 128x64
 * graphic lcd controller behind an 8-bit 80-family host port.
 * assumes: host pins are asynchronous and slower than several clocks;
 * line, frame, dot and icon inputs come from display timing on clock_i.
 */
// Overview of operation
// R01 - host keeps chip select low per transfer
// R02 - register select low ram, high register
// R03 - data write stores byte at pointers
// R04 - first ram read after address is dummy
// R05 - column address four bits, 00h to 0fh
// R06 - reversal maps column to 0fh minus column
// R07 - row loaded low nibble then high bits
// R08 - rows up to 42h, 40h+ segment ram
// R09 - start line picks line on first common
// R10 - alternation every count plus one lines
// R11 - alternation per frame when disabled
// R12 - view one bit zero graphic on
// R13 - bit one forces dots lit, beats inverse
// R14 - bit two segments on, else ground
// R15 - bit three reverses common scan direction
// R16 - host sets extension bits zero and one
// R17 - reversal also mirrors graphic bit order
// R18 - segment ram column remap, order kept
// R19 - swap bit stores graphic bytes reversed
// R20 - inverse bit lights dots for zeros
// R21 - bank bit selects extended register set
// R22 - host strobes active low, shared bus
// R23 - registers reset zero, readable fields
// R24 - writes latch on strobe rise
`timescale 1ns/10ps
module lcdc_decoder
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // host port pins
    input wire logic chip_select_n_i,
    input wire logic reg_select_i,
    input wire logic wr_n_i,
    input wire logic rd_n_i,
    input wire logic [7:0] db_i,
    output logic [7:0] db_o,
    output logic db_oe_n_o,
    // display timing
    input wire logic line_tick_i,
    input wire logic frame_tick_i,
    input wire logic dot_data_i,
    input wire logic [7:0] icon_data_i,
    // display controls
    output lcdc_pkg::lcdc_view_t view_o,
    output logic [5:0] display_line_o,
    output logic dot_lit_o,
    output logic [7:0] icon_drive_o,
    output logic alt_o
);
    // whole state of the decoder
    typedef struct packed {
        lcdc_pkg::lcdc_pins_t s1;
        lcdc_pkg::lcdc_pins_t s2;
        logic wr_prev;
        logic rd_prev;
        logic [3:0] col;
        logic [6:0] row;
        logic [5:0] first_line;
        logic [5:0] alt_count;
        logic [3:0] view1;
        logic [1:0] view1_ext;
        logic [3:0] view2;
        logic bank;
        logic [3:0] sel;
        logic [7:0] rd_buf;
        logic [5:0] scan_row;
        logic [5:0] line;
        logic [7:0] db;
        logic db_oe_n;
        logic dot_lit;
        logic [7:0] icon;
    } lcdc_state_t;

    lcdc_state_t state_q;
    lcdc_state_t state_d;
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [7:0] mem [0:lcdc_pkg::RAM_WORDS-1];
    logic wr_event;
    logic rd_end;
    logic rd_active;
    logic [3:0] col_int;
    logic [10:0] ram_addr;
    logic [7:0] wr_data;
    logic graphic_row;

    // reset release through two flops
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_sync_q <= 2'h0;
        end
        else
        begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // strobe events seen on the second sync stage
    assign wr_event = state_q.s2.wr_n && !state_q.wr_prev && !state_q.s2.chip_select_n; // [R24] [R01]
    assign rd_end = state_q.s2.rd_n && !state_q.rd_prev && !state_q.s2.chip_select_n;
    assign rd_active = !state_q.s2.rd_n && !state_q.s2.chip_select_n; // [R24]

    // internal ram location from the pointers
    assign col_int = state_q.view2[lcdc_pkg::V2_REF] ? (lcdc_pkg::COL_LAST - state_q.col) : state_q.col; // [R06] [R18]
    assign ram_addr = 11'({state_q.row, col_int});
    assign graphic_row = state_q.row < lcdc_pkg::ROW_SEGMENT;

    // write data: mirror and swap apply to graphic rows only
    always_comb
    begin
        wr_data = state_q.s2.db;
        if (graphic_row && (state_q.view2[lcdc_pkg::V2_REF] ^ state_q.view2[lcdc_pkg::V2_SWAP])) // [R17] [R19]
        begin
            for (int i = 0; i < 8; i++)
            begin
                wr_data[i] = state_q.s2.db[7-i];
            end
        end
    end

    // display ram write port
    always_ff @(posedge clock_i)
    begin
        if (wr_event && !state_q.s2.reg_select && state_q.row <= lcdc_pkg::ROW_LAST) // [R02] [R03] [R08]
        begin
            mem[ram_addr] <= wr_data;
        end
    end

    // next state of the whole decoder
    always_comb
    begin
        state_d = state_q;
        // two-stage pin synchronisers
        state_d.s1 = '{chip_select_n_i, reg_select_i, wr_n_i, rd_n_i, db_i};
        state_d.s2 = state_q.s1;
        state_d.wr_prev = state_q.s2.wr_n;
        state_d.rd_prev = state_q.s2.rd_n;

        // register writes on the strobe rise
        if (wr_event && state_q.s2.reg_select) // [R02]
        begin
            state_d.sel = state_q.s2.db[7:4];
            if (state_q.s2.db[7:4] == lcdc_pkg::CODE_BANK)
            begin
                state_d.bank = state_q.s2.db[0]; // [R21]
            end
            else if (state_q.bank)
            begin
                // extended set: only view one extension lives here
                if (state_q.s2.db[7:4] == lcdc_pkg::CODE_VIEW1)
                begin
                    state_d.view1_ext = state_q.s2.db[1:0]; // [R21]
                end
            end
            else
            begin
                case (state_q.s2.db[7:4])
                    lcdc_pkg::CODE_COL: state_d.col = state_q.s2.db[3:0]; // [R05]
                    lcdc_pkg::CODE_ROW_LO: state_d.row[3:0] = state_q.s2.db[3:0];
                    lcdc_pkg::CODE_ROW_HI: state_d.row[6:4] = state_q.s2.db[2:0];
                    lcdc_pkg::CODE_LINE_LO: state_d.first_line[3:0] = state_q.s2.db[3:0]; // [R09]
                    lcdc_pkg::CODE_LINE_HI: state_d.first_line[5:4] = state_q.s2.db[1:0]; // [R09]
                    lcdc_pkg::CODE_ALT_LO: state_d.alt_count[3:0] = state_q.s2.db[3:0]; // [R10]
                    lcdc_pkg::CODE_ALT_HI: state_d.alt_count[5:4] = state_q.s2.db[1:0]; // [R10]
                    lcdc_pkg::CODE_VIEW1: state_d.view1 = state_q.s2.db[3:0]; // [R12] [R13] [R14] [R15]
                    lcdc_pkg::CODE_VIEW2: state_d.view2 = state_q.s2.db[3:0]; // [R19] [R20]
                    default: state_d.sel = state_q.sel;
                endcase
            end
        end

        // ram read: present buffer, refill it when the strobe ends
        if (rd_end && !state_q.s2.reg_select)
        begin
            state_d.rd_buf = mem[ram_addr]; // [R04]
        end

        // read bus driven only while the strobe is low
        state_d.db_oe_n = 1'b1;
        state_d.db = lcdc_pkg::RST_BYTE;
        if (rd_active) // [R24]
        begin
            state_d.db_oe_n = 1'b0;
            if (!state_q.s2.reg_select)
            begin
                state_d.db = state_q.rd_buf; // [R04]
            end
            else
            begin
                // selected register field in low bits
                case (state_q.sel)
                    lcdc_pkg::CODE_COL: state_d.db = {4'h0, state_q.col}; // [R23]
                    lcdc_pkg::CODE_ROW_LO: state_d.db = {4'h0, state_q.row[3:0]};
                    lcdc_pkg::CODE_ROW_HI: state_d.db = {5'h00, state_q.row[6:4]};
                    lcdc_pkg::CODE_LINE_LO: state_d.db = {4'h0, state_q.first_line[3:0]};
                    lcdc_pkg::CODE_LINE_HI: state_d.db = {6'h00, state_q.first_line[5:4]};
                    lcdc_pkg::CODE_ALT_LO: state_d.db = {4'h0, state_q.alt_count[3:0]};
                    lcdc_pkg::CODE_ALT_HI: state_d.db = {6'h00, state_q.alt_count[5:4]};
                    lcdc_pkg::CODE_VIEW1: state_d.db = state_q.bank ? {6'h00, state_q.view1_ext} :
                                                                    {4'h0, state_q.view1};
                    lcdc_pkg::CODE_VIEW2: state_d.db = {4'h0, state_q.view2};
                    lcdc_pkg::CODE_BANK: state_d.db = {7'h00, state_q.bank};
                    default: state_d.db = lcdc_pkg::RST_BYTE;
                endcase
            end
        end

        // scan row counter, reset per frame
        if (frame_tick_i)
        begin
            state_d.scan_row = 6'h00;
        end
        else if (line_tick_i)
        begin
            state_d.scan_row = state_q.scan_row + 6'h01;
        end
        // ram line on the current common, start line offset
        if (state_q.view1[lcdc_pkg::V1_SHIFT]) // [R15]
        begin
            state_d.line = state_q.first_line + (lcdc_pkg::LINE_LAST - state_q.scan_row); // [R09]
        end
        else
        begin
            state_d.line = state_q.first_line + state_q.scan_row; // [R09]
        end

        // dot shading: off, forced, then inverse
        if (!state_q.view1[lcdc_pkg::V1_ON]) // [R12]
        begin
            state_d.dot_lit = 1'b0;
        end
        else if (state_q.view1[lcdc_pkg::V1_ALL]) // [R13]
        begin
            state_d.dot_lit = 1'b1;
        end
        else
        begin
            state_d.dot_lit = dot_data_i ^ state_q.view2[lcdc_pkg::V2_REV]; // [R20]
        end

        // icon terminals grounded when disabled
        state_d.icon = state_q.view1[lcdc_pkg::V1_SEG] ? icon_data_i : lcdc_pkg::RST_BYTE; // [R14]
    end

    // state register, cleared on reset except the active-low pin, strobe and bus enable bits, which reset high
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= '0; // [R23]
            state_q.s1.chip_select_n <= 1'b1;
            state_q.s1.wr_n <= 1'b1;
            state_q.s1.rd_n <= 1'b1;
            state_q.s2.chip_select_n <= 1'b1;
            state_q.s2.wr_n <= 1'b1;
            state_q.s2.rd_n <= 1'b1;
            state_q.wr_prev <= 1'b1;
            state_q.rd_prev <= 1'b1;
            state_q.db_oe_n <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // alternation signal generator
    lcdc_alternator i_lcdc_alternator
    (
        .clock_i(clock_i),
        .rst_n_i(rst_n),
        .line_tick_i(line_tick_i),
        .frame_tick_i(frame_tick_i),
        .enable_i(state_q.view2[lcdc_pkg::V2_LINE_ALTERNATION_ENABLE]),
        .count_i(state_q.alt_count),
        .alt_o(alt_o)
    );

    // outputs straight from state
    assign db_o = state_q.db;
    assign db_oe_n_o = state_q.db_oe_n;
    assign display_line_o = state_q.line;
    assign dot_lit_o = state_q.dot_lit;
    assign icon_drive_o = state_q.icon;
    assign view_o = '{state_q.view1[lcdc_pkg::V1_ON], state_q.view1[lcdc_pkg::V1_ALL],
                      state_q.view1[lcdc_pkg::V1_SEG], state_q.view1[lcdc_pkg::V1_SHIFT],
                      state_q.view1_ext[1], state_q.view1_ext[0], state_q.view2[lcdc_pkg::V2_REV],
                      state_q.view2[lcdc_pkg::V2_LINE_ALTERNATION_ENABLE], state_q.first_line, state_q.alt_count};

    // checks on the decoder behaviour
    a_col_load: assert property (@(posedge clock_i) disable iff (!rst_n) // [R05]
        (wr_event && state_q.s2.reg_select && !state_q.bank && state_q.s2.db[7:4] == 4'h0)
        |=> state_q.col == $past(state_q.s2.db[3:0]))
        else $error("column pointer not loaded");
    a_idle_cs: assert property (@(posedge clock_i) disable iff (!rst_n) // [R01] [R24]
        state_q.s2.chip_select_n |=> db_oe_n_o)
        else $error("bus driven without chip select");
    a_ref_map: assert property (@(posedge clock_i) disable iff (!rst_n) // [R06]
        state_q.view2[0] |-> col_int == 4'hf - state_q.col)
        else $error("reversed column map wrong");
    a_mirror_data: assert property (@(posedge clock_i) disable iff (!rst_n) // [R17] [R19]
        (graphic_row && state_q.view2[0] && !state_q.view2[1]) |-> wr_data[0] == state_q.s2.db[7])
        else $error("mirror write data wrong");
    a_seg_order: assert property (@(posedge clock_i) disable iff (!rst_n) // [R18]
        !graphic_row |-> wr_data == state_q.s2.db)
        else $error("segment data reordered");
    a_all_lit: assert property (@(posedge clock_i) disable iff (!rst_n) // [R13]
        (state_q.view1[0] && state_q.view1[1]) |=> dot_lit_o)
        else $error("forced dots not lit");
    a_off_dark: assert property (@(posedge clock_i) disable iff (!rst_n) // [R12]
        !state_q.view1[0] |=> !dot_lit_o)
        else $error("display off but dot lit");
    a_icon_ground: assert property (@(posedge clock_i) disable iff (!rst_n) // [R14]
        !state_q.view1[2] |=> icon_drive_o == 8'h00)
        else $error("icon terminals not grounded");
    a_inverse: assert property (@(posedge clock_i) disable iff (!rst_n) // [R20]
        (state_q.view1[0] && !state_q.view1[1]) |=> dot_lit_o == ($past(dot_data_i) ^ $past(state_q.view2[3])))
        else $error("inverse video wrong");
    a_bank_guard: assert property (@(posedge clock_i) disable iff (!rst_n) // [R21]
        (wr_event && state_q.bank) |=> $stable(state_q.view1))
        else $error("normal register written in extended bank");
    a_read_buf: assert property (@(posedge clock_i) disable iff (!rst_n) // [R04]
        (rd_active && !state_q.s2.reg_select) |=> db_o == $past(state_q.rd_buf))
        else $error("ram read not from buffer");
    a_line_start: assert property (@(posedge clock_i) disable iff (!rst_n) // [R09]
        (frame_tick_i && !state_q.view1[3]) ##1 !state_q.view1[3]
        |=> display_line_o == $past(state_q.first_line))
        else $error("start line not on first common");

    c_ram_write: cover property (@(posedge clock_i) disable iff (!rst_n)
        wr_event && !state_q.s2.reg_select);
    c_reg_read: cover property (@(posedge clock_i) disable iff (!rst_n)
        rd_active && state_q.s2.reg_select);
    c_reversed: cover property (@(posedge clock_i) disable iff (!rst_n)
        wr_event && state_q.view2[0] && graphic_row);
    c_bank: cover property (@(posedge clock_i) disable iff (!rst_n) state_q.bank);
endmodule : lcdc_decoder

// ==== design/lcdc_pkg.sv ====
/*
 * lcdc_pkg: shared constants and carrier types for the graphic lcd
 * command and display-ram access decoder.
 * assumes: one 25 mhz clock; host pins arrive asynchronously.
 */
package lcdc_pkg;
    // host bus and ram geometry
    localparam int unsigned DATA_W = 8;
    localparam int unsigned COL_W = 4;
    localparam int unsigned ROW_W = 7;
    localparam int unsigned LINE_W = 6;
    localparam int unsigned RAM_ADDR_W = 11;
    localparam int unsigned RAM_WORDS = 1072;
    // last legal row, first row of the segment ram
    localparam logic [6:0] ROW_LAST = 7'h42;
    localparam logic [6:0] ROW_SEGMENT = 7'h40;
    localparam logic [3:0] COL_LAST = 4'hf;
    localparam logic [5:0] LINE_LAST = 6'h3f;
    // command codes in the upper nibble with register select high
    localparam logic [3:0] CODE_COL = 4'h0;
    localparam logic [3:0] CODE_ROW_LO = 4'h2;
    localparam logic [3:0] CODE_ROW_HI = 4'h3;
    localparam logic [3:0] CODE_LINE_LO = 4'h4;
    localparam logic [3:0] CODE_LINE_HI = 4'h5;
    localparam logic [3:0] CODE_ALT_LO = 4'h6;
    localparam logic [3:0] CODE_ALT_HI = 4'h7;
    localparam logic [3:0] CODE_VIEW1 = 4'h8;
    localparam logic [3:0] CODE_VIEW2 = 4'h9;
    localparam logic [3:0] CODE_BANK = 4'hf;
    // field positions of view control one and two
    localparam int unsigned V1_ON = 0;
    localparam int unsigned V1_ALL = 1;
    localparam int unsigned V1_SEG = 2;
    localparam int unsigned V1_SHIFT = 3;
    localparam int unsigned V2_REF = 0;
    localparam int unsigned V2_SWAP = 1;
    localparam int unsigned V2_LINE_ALTERNATION_ENABLE = 2;
    localparam int unsigned V2_REV = 3;
    // reset values
    localparam logic [3:0] RST_NIBBLE = 4'h0;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // display control bundle presented to the drive logic
    typedef struct packed {
        logic graphic_on;
        logic force_all_lit;
        logic icon_segments_enable;
        logic scan_reverse;
        logic ext_level_select;
        logic int_level_select;
        logic inverse_video;
        logic line_alternation_enable;
        logic [5:0] first_line_bits;
        logic [5:0] alternation_count_bits;
    } lcdc_view_t;

    // host pin group after synchronisation
    typedef struct packed {
        logic chip_select_n;
        logic reg_select;
        logic wr_n;
        logic rd_n;
        logic [7:0] db;
    } lcdc_pins_t;
endpackage : lcdc_pkg

// ==== test/lcd_command_register_decoder_tb.sv ====
/*
 * lcd_command_register_decoder_tb: self-checking bench for lcdc_decoder.
 * assumes: lcdc_pkg and lcdc_host_model compiled first; 25 mhz clock.
 */
`timescale 1ns/10ps
module lcd_command_register_decoder_tb;
    // clock, reset and display timing stimulus
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic line_tick = 1'b0;
    logic frame_tick = 1'b0;
    logic dot_data = 1'b0;
    logic [7:0] icon_data = 8'h5a;
    // host pins and device outputs
    logic cs_n, rs, wr_n, rd_n;
    logic [7:0] db_w, db_o, icon_drive;
    logic db_oe_n, dot_lit, alt, alt_was;
    logic [5:0] display_line;
    lcdc_pkg::lcdc_view_t view, exp_v;
    // bookkeeping
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [7:0] rd;
    // register table rows: command byte, field read back
    typedef struct packed {logic [7:0] cmd; logic [3:0] back;} lcdc_row_t;
    // row pointer rows stay inside the legal row range
    lcdc_row_t rows [9] = '{'{8'h0a, 4'ha}, '{8'h25, 4'h5}, '{8'h33, 4'h3}, '{8'h4d, 4'hd},
        '{8'h5e, 4'h2}, '{8'h63, 4'h3}, '{8'h7d, 4'h1}, '{8'h85, 4'h5}, '{8'h96, 4'h6}};

    always #20 clock_i = ~clock_i;

    lcdc_decoder i_lcdc_decoder (.clock_i(clock_i), .rst_n_i(rst_n_i), .chip_select_n_i(cs_n),
        .reg_select_i(rs), .wr_n_i(wr_n), .rd_n_i(rd_n), .db_i(db_w), .db_o(db_o),
        .db_oe_n_o(db_oe_n), .line_tick_i(line_tick), .frame_tick_i(frame_tick),
        .dot_data_i(dot_data), .icon_data_i(icon_data), .view_o(view),
        .display_line_o(display_line), .dot_lit_o(dot_lit), .icon_drive_o(icon_drive), .alt_o(alt));

    lcdc_host_model i_lcdc_host_model (.clock_i(clock_i), .rd_data_i(db_o), .rd_oe_n_i(db_oe_n),
        .chip_select_n_o(cs_n), .reg_select_o(rs), .wr_n_o(wr_n), .rd_n_o(rd_n), .db_o(db_w));

    // compare and count
    task automatic check(input string name, input logic [19:0] seen, input logic [19:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // verdict and end of run
    task automatic close_out();
        if (mismatches == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out

    // hang guard
    always @(posedge clock_i)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            mismatches++;
            close_out();
        end
    end

    // register and ram writes
    task automatic wr(input logic [7:0] b);
        i_lcdc_host_model.write_cycle(1'b0, 1'b1, b);
    endtask : wr
    task automatic ramw(input logic [7:0] b);
        i_lcdc_host_model.write_cycle(1'b0, 1'b0, b);
    endtask : ramw

    // pointers: column, then row low nibble before high bits
    task automatic set_ptr(input logic [3:0] col, input logic [6:0] row);
        wr({4'h0, col});
        wr({4'h2, row[3:0]});
        wr({5'h06, row[6:4]});
    endtask : set_ptr

    // load pointers, discard one read, compare the next
    task automatic ram_at(input logic [3:0] col, input logic [6:0] row, input logic [7:0] exp);
        set_ptr(col, row);
        i_lcdc_host_model.read_cycle(1'b0, rd);
        i_lcdc_host_model.read_cycle(1'b0, rd);
        check("ram_byte", {12'h000, rd}, {12'h000, exp});
    endtask : ram_at

    // shading of one dot under given view settings
    task automatic dot(input logic [7:0] v1, input logic [7:0] v2, input logic e, input string n);
        wr(v1);
        wr(v2);
        dot_data = 1'b1;
        repeat (3) @(posedge clock_i);
        #1;
        check(n, {19'h00000, dot_lit}, {19'h00000, e});
    endtask : dot

    // one-cycle display timing pulse, then let it settle
    task automatic pulse(input logic is_frame);
        frame_tick = is_frame;
        line_tick = ~is_frame;
        @(posedge clock_i);
        #1;
        frame_tick = 1'b0;
        line_tick = 1'b0;
        repeat (3) @(posedge clock_i);
        #1;
    endtask : pulse

    initial
    begin
        repeat (12) @(posedge clock_i);
        #1;
        rst_n_i = 1'b1;
        repeat (4) @(posedge clock_i);
        #1;
        check("view_rst", view, 20'h00000);
        check("oe_rst", {19'h00000, db_oe_n}, 20'h00001);
        foreach (rows[i])
        begin
            wr(rows[i].cmd);
            i_lcdc_host_model.read_cycle(1'b1, rd);
            check("reg_read", {16'h0000, rd[3:0]}, {16'h0000, rows[i].back});
        end
        exp_v = '0;
        exp_v.graphic_on = 1'b1;
        exp_v.icon_segments_enable = 1'b1;
        exp_v.line_alternation_enable = 1'b1;
        exp_v.first_line_bits = 6'h2d;
        exp_v.alternation_count_bits = 6'h13;
        check("view_fields", view, exp_v);
        i_lcdc_host_model.write_cycle(1'b1, 1'b1, 8'h8f);
        check("cs_high", view, exp_v);
        // plain, swapped, reversed and segment-row stores
        wr(8'h90);
        set_ptr(4'h3, 7'h05);
        ramw(8'hc5);
        ram_at(4'h3, 7'h05, 8'hc5);
        wr(8'h92);
        set_ptr(4'h4, 7'h05);
        ramw(8'h01);
        wr(8'h90);
        ram_at(4'h4, 7'h05, 8'h80);
        wr(8'h91);
        set_ptr(4'h2, 7'h06);
        ramw(8'h03);
        wr(8'h90);
        ram_at(4'hd, 7'h06, 8'hc0);
        wr(8'h91);
        set_ptr(4'hf, 7'h40);
        ramw(8'h03);
        wr(8'h90);
        ram_at(4'h0, 7'h40, 8'h03);
        // extended bank: code 8 reaches the level bits only
        wr(8'hf1);
        wr(8'h82);
        wr(8'hf0);
        exp_v.line_alternation_enable = 1'b0;
        exp_v.ext_level_select = 1'b1;
        check("bank_view", view, exp_v);
        dot(8'h81, 8'h98, 1'b0, "dot_inverse");
        dot(8'h83, 8'h98, 1'b1, "dot_all_lit");
        dot(8'h80, 8'h90, 1'b0, "dot_off");
        wr(8'h84);
        check("icon_on", {12'h000, icon_drive}, 20'h0005a);
        wr(8'h80);
        check("icon_off", {12'h000, icon_drive}, 20'h00000);
        // frame alternation, then every two lines
        alt_was = alt;
        pulse(1'b1);
        check("alt_frame", {19'h00000, alt}, {19'h00000, ~alt_was});
        wr(8'h61);
        wr(8'h70);
        wr(8'h94);
        alt_was = alt;
        pulse(1'b0);
        check("alt_line1", {19'h00000, alt}, {19'h00000, alt_was});
        pulse(1'b0);
        check("alt_line2", {19'h00000, alt}, {19'h00000, ~alt_was});
        // two lines after the frame: start line 2dh plus 2, then scan reversed
        check("line_fwd", {14'h0000, display_line}, 20'h0002f);
        wr(8'h88);
        check("line_rev", {14'h0000, display_line}, 20'h0002a);
        // reset in mid-run clears every register
        rst_n_i = 1'b0;
        @(posedge clock_i);
        #1;
        check("view_rst2", view, 20'h00000);
        rst_n_i = 1'b1;
        repeat (4) @(posedge clock_i);
        #1;
        i_lcdc_host_model.read_cycle(1'b1, rd);
        check("col_rst", {12'h000, rd}, 20'h00000);
        check("oe_idle", {19'h00000, db_oe_n}, 20'h00001);
        close_out();
    end
endmodule : lcd_command_register_decoder_tb

// ==== test/lcdc_host_model.sv ====
/*
 * lcdc_host_model: 80-family host that drives the decoder's parallel port.
 * assumes: the device syncs its pins through two flops, so every write strobe
 * phase lasts four clocks and data stays put well past the write rise.
 */
`timescale 1ns/10ps
module lcdc_host_model
(
    // clock
    input wire logic clock_i,
    // read answer from the device
    input wire logic [7:0] rd_data_i,
    input wire logic rd_oe_n_i,
    // host pins
    output logic chip_select_n_o,
    output logic reg_select_o,
    output logic wr_n_o,
    output logic rd_n_o,
    output logic [7:0] db_o
);
    // idle bus: deselected, both strobes high
    initial
    begin
        chip_select_n_o = 1'b1;
        reg_select_o = 1'b0;
        wr_n_o = 1'b1;
        rd_n_o = 1'b1;
        db_o = 8'h00;
    end

    // wait some edges, then step just off the last one
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : tick

    // one write cycle; cs_n high makes a cycle the device must ignore
    task automatic write_cycle(input logic cs_n, input logic rs, input logic [7:0] data);
        tick(1);
        chip_select_n_o = cs_n;
        reg_select_o = rs;
        db_o = data;
        wr_n_o = 1'b0;
        tick(4);
        wr_n_o = 1'b1;
        tick(4);
        chip_select_n_o = 1'b1;
        db_o = ~data; // released bus shows no stale value
        tick(4);
    endtask : write_cycle

    // one read cycle; data taken where the enable is first seen low
    task automatic read_cycle(input logic rs, output logic [7:0] data);
        int n;
        n = 0;
        data = 8'hxx;
        tick(1);
        chip_select_n_o = 1'b0;
        reg_select_o = rs;
        rd_n_o = 1'b0;
        while (rd_oe_n_i !== 1'b0 && n < 8)
        begin
            tick(1);
            n++;
        end
        // no enable seen: hand back unknown so the compare trips
        data = (rd_oe_n_i === 1'b0) ? rd_data_i : 8'hxx;
        tick(2);
        rd_n_o = 1'b1;
        tick(5);
        chip_select_n_o = 1'b1;
        tick(3);
    endtask : read_cycle
endmodule : lcdc_host_model
